// ---- step_seq_cfg.svh ----
/*
 Register word indices, field positions, masks, reset values and
 arithmetic constants of the step/direction microstep sequencer.
 Assumes inclusion by bare name from the regulator and sequencer design files.
*/
`ifndef STEP_SEQ_CFG_SVH
`define STEP_SEQ_CFG_SVH

// Register word indices (byte address is four times the index)
`define IDX_CTRL       4'h0
`define IDX_CURRENT    4'h1
`define IDX_LOAD       4'h2
`define IDX_COOL_THRS  4'h3
`define IDX_VEL_LIMIT  4'h4
`define IDX_STATUS     4'h5
`define IDX_COIL       4'h6
`define IDX_INTERVAL   4'h7

// Writable bits per register
`define MASK_CTRL      32'h0000_00FF
`define MASK_CURRENT   32'h0000_1F1F
`define MASK_LOAD      32'h0007_FFFF
`define MASK_THRS      32'h000F_FFFF

// Reset values
`define RST_CTRL       32'h0000_0000
`define RST_CURRENT    32'h0000_0810
`define RST_LOAD       32'h0000_0000
`define RST_COOL_THRS  32'h0000_0000
`define RST_VEL_LIMIT  32'h0000_0000

// Control word fields
`define CTRL_DUAL_EDGE 0
`define CTRL_MRES_LSB  1
`define CTRL_FILTER    5
`define CTRL_MIN_QUART 6
`define CTRL_HOLD_SEL  7

// Current and load word fields
`define CUR_RUN_LSB    0
`define CUR_HOLD_LSB   8
`define LD_LO_LSB      0
`define LD_HYST_LSB    4
`define LD_INC_LSB     8
`define LD_DEC_LSB     10
`define LD_TRIM_LSB    12

// Status and coil word fields
`define ST_MSC_LSB     0
`define ST_CS_LSB      16
`define ST_ACTIVE      24
`define COIL_A_LSB     0
`define COIL_B_LSB     16

// Sequencer and table constants
`define MRES_MAX       4'h8
`define QUARTER_WAVE   10'h100
`define SINE_PEAK      27'h00000F8
`define SINE_DEN       19'h50000
`define FULLSTEP_MAG   9'h0AF
`define INTERVAL_MAX   20'hFFFFF

`endif

// ---- step_seq_pkg.sv ----
/*
 Types shared by the sequencer and its current regulator.
 Assumes the constants header is on the include path.
*/
`default_nettype none
package step_seq_pkg;

	// Register bus handshake states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_t;

	// Regulator configuration carried as one word
	typedef struct packed {
		logic [4:0]  run_current_scale;
		logic [4:0]  hold_current_scale;
		logic        hold_sel;
		logic        min_quarter;
		logic        load_filter;
		logic [3:0]  lower_load_threshold;
		logic [3:0]  upper_load_hysteresis;
		logic [1:0]  current_increment_step;
		logic [1:0]  current_decrement_rate;
		logic [19:0] cool_thrs;
		logic [19:0] upper_velocity_limit;
	} regul_cfg_t;

	// One load reading with its strobe
	typedef struct packed {
		logic       valid;
		logic [9:0] load_measure_value;
	} load_sample_t;

endpackage
`default_nettype wire

// ---- current_regulator.sv ----
/*
 Load-adaptive coil current scale regulator.
 Assumes one clock, configuration from the register bank and a
 load reading strobe that lasts one cycle per reading.
*/
`timescale 1ns/1ps
`default_nettype none
`include "step_seq_cfg.svh"
module current_regulator (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// Configuration and measured step interval
	input  wire step_seq_pkg::regul_cfg_t  cfg,
	input  wire logic [19:0]               step_interval,
	// Load readings
	input  wire step_seq_pkg::load_sample_t load_in,
	// Regulated scale
	output logic [4:0]                     current_scale_reg,
	output logic                           regul_active_reg
);
	logic [4:0] lower_limit;
	logic [4:0] hi_sum;
	logic [9:0] lo_thr;
	logic [9:0] hi_thr;
	logic       take;
	logic       is_low;
	logic       is_high;
	logic       active_next;
	logic [1:0] filt_cnt_reg;
	logic [4:0] dn_cnt_reg;
	logic [4:0] dn_need;
	logic [5:0] cs_raw;

	function automatic logic [4:0] clamp5(input logic [5:0] v, input logic [4:0] lo, input logic [4:0] hi);
		if (v > {1'b0, hi})
			clamp5 = hi;
		else if (v < {1'b0, lo})
			clamp5 = lo;
		else
			clamp5 = v[4:0];
	endfunction

	// Limits, thresholds and reading classification
	always_comb begin
		lower_limit = cfg.min_quarter ? (cfg.run_current_scale >> 2) : (cfg.run_current_scale >> 1);
		lo_thr = {1'b0, cfg.lower_load_threshold, 5'h00};
		hi_sum = 5'({1'b0, cfg.lower_load_threshold} + {1'b0, cfg.upper_load_hysteresis} + 5'h01);
		hi_thr = {hi_sum, 5'h00};
		active_next = (cfg.lower_load_threshold != 4'h0)
			&& (step_interval <= cfg.cool_thrs)
			&& (step_interval >= cfg.upper_velocity_limit);
		take = load_in.valid && (!cfg.load_filter || filt_cnt_reg == 2'h3);
		is_low = take && (load_in.load_measure_value < lo_thr);
		is_high = take && (load_in.load_measure_value >= hi_thr) && !is_low;
		unique case (cfg.current_decrement_rate)
			2'h0: dn_need = 5'h1F;
			2'h1: dn_need = 5'h07;
			2'h2: dn_need = 5'h01;
			2'h3: dn_need = 5'h00;
		endcase
		if (is_low)
			cs_raw = {1'b0, current_scale_reg} + (6'h01 << cfg.current_increment_step);
		else if (is_high && dn_cnt_reg >= dn_need && current_scale_reg != 5'h00)
			cs_raw = {1'b0, current_scale_reg} - 6'h01;
		else
			cs_raw = {1'b0, current_scale_reg};
	end

	// Reading divider for the slow filter
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			filt_cnt_reg <= 2'h0;
		else if (load_in.valid)
			filt_cnt_reg <= filt_cnt_reg + 2'h1;
	end

	// High-reading count per decrement
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			dn_cnt_reg <= 5'h00;
		else if (!regul_active_reg || is_low)
			dn_cnt_reg <= 5'h00;
		else if (is_high)
			dn_cnt_reg <= (dn_cnt_reg >= dn_need) ? 5'h00 : dn_cnt_reg + 5'h01;
	end

	// Regulation enable and scale
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regul_active_reg <= 1'b0;
			current_scale_reg <= 5'h00;
		end else begin
			regul_active_reg <= active_next;
			if (!regul_active_reg)
				current_scale_reg <= cfg.hold_sel ? cfg.hold_current_scale : cfg.run_current_scale;
			else
				current_scale_reg <= clamp5(cs_raw, lower_limit, cfg.run_current_scale);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_scale_bounds;
		regul_active_reg && $past(regul_active_reg) && $stable(cfg)
			|-> current_scale_reg <= cfg.run_current_scale && current_scale_reg >= lower_limit;
	endproperty
	a_scale_bounds: assert property (p_scale_bounds) else $error("scale left its limits");

	property p_plain_current;
		!regul_active_reg ##1 $stable(cfg)
			|-> current_scale_reg == (cfg.hold_sel ? cfg.hold_current_scale : cfg.run_current_scale);
	endproperty
	a_plain_current: assert property (p_plain_current) else $error("plain current not applied");

	property p_raise;
		regul_active_reg && is_low && $past(regul_active_reg) && $stable(cfg)
			|=> current_scale_reg == clamp5({1'b0, $past(current_scale_reg)} + (6'h01 << $past(cfg.current_increment_step)),
				$past(lower_limit), $past(cfg.run_current_scale));
	endproperty
	a_raise: assert property (p_raise) else $error("scale not raised by step");

	property p_drop_each;
		regul_active_reg && $past(regul_active_reg) && $stable(cfg) && cfg.current_decrement_rate == 2'h3
			&& is_high && current_scale_reg > lower_limit && current_scale_reg <= cfg.run_current_scale
			|=> current_scale_reg == $past(current_scale_reg) - 5'h01;
	endproperty
	a_drop_each: assert property (p_drop_each) else $error("scale not lowered");

	property p_filter_skip;
		cfg.load_filter && load_in.valid && filt_cnt_reg != 2'h3 |-> !take;
	endproperty
	a_filter_skip: assert property (p_filter_skip) else $error("filtered reading used");

endmodule // current_regulator
`default_nettype wire

// ---- step_dir_microstep_sequencer.sv ----
/*
 Step/direction microstep sequencer with register bank and the
 load-adaptive current regulator.
 Assumes one 200 MHz clock, step and direction from an external
 motion controller, and an Avalon-MM master with waitrequest.
*/
// Summary of operation
// - Dual-edge set: both step edges are active
// - Dual-edge clear: only rising step edges active
// - Step and direction synchronised before use
// - 1024-entry sine table spans four full steps
// - Direction low adds width, high subtracts
// - Width doubles per resolution, 1 up to 256
// - Resolution drop snaps to nearest valid position
// - Full step visits 128, 384, 640, 896
// - Half step starts 64, moves 128
// - Quarter step starts 32, moves 64
// - Full-step positions drive about 0.71 peak
// - Reduced positions equidistant, avoid zero and peak
// - Filter bit cuts regulation rate by four
// - Scale kept between run and lower limit
// - Below low velocity, plain run or hold
// - Above upper velocity, regulation is off
// - Increment and decrement rates set separately
// - Low reading raises scale by 1,2,4,8
// - Decrement once per 32,8,2,1 high readings
// - Thresholds scaled by 32; zero disables
`timescale 1ns/1ps
`default_nettype none
`include "step_seq_cfg.svh"
module step_dir_microstep_sequencer (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// Avalon-MM slave
	input  wire logic [5:0]                 address,
	input  wire logic                       read,
	input  wire logic                       write,
	input  wire logic [3:0]                 byteenable,
	input  wire logic [31:0]                writedata,
	output logic [31:0]                     readdata,
	output logic                            waitrequest,
	// Step and direction inputs
	input  wire logic                       step_in,
	input  wire logic                       dir_in,
	// Load readings
	input  wire step_seq_pkg::load_sample_t load_in,
	// Coil drive and status
	output logic signed [8:0]               coil_a_current,
	output logic signed [8:0]               coil_b_current,
	output logic [9:0]                      microstep_position,
	output logic [4:0]                      current_scale,
	output logic                            regulation_active,
	output logic [6:0]                      load_threshold_trim
);
	logic [31:0]              chopper_config_reg;
	logic [31:0]              current_cfg_reg;
	logic [31:0]              load_cfg_reg;
	logic [31:0]              cool_thrs_reg;
	logic [31:0]              velocity_limit_reg;
	logic [31:0]              readdata_reg;
	logic [31:0]              rd_word;
	logic                     waitrequest_reg;
	step_seq_pkg::bus_state_t bus_state_reg;
	logic                     step_meta_reg;
	logic                     step_sync_reg;
	logic                     step_prev_reg;
	logic                     dir_meta_reg;
	logic                     dir_sync_reg;
	logic                     step_event;
	logic                     dual_edge;
	logic [3:0]               mres;
	logic [9:0]               msc_reg;
	logic [9:0]               msc_next;
	logic [9:0]               msc_base;
	logic signed [8:0]        coil_a_reg;
	logic signed [8:0]        coil_b_reg;
	logic [19:0]              interval_cnt_reg;
	logic [19:0]              step_interval_reg;
	logic [4:0]               cs_value;
	logic                     cs_active;
	step_seq_pkg::regul_cfg_t regul_cfg;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		be_merge = ((old & ~m) | (wd & m)) & mask;
	endfunction

	// Table distance per step at a resolution
	function automatic logic [9:0] step_width(input logic [3:0] res);
		step_width = 10'h001 << res;
	endfunction

	// Nearest position valid at a resolution
	function automatic logic [9:0] snap_position(input logic [9:0] pos, input logic [3:0] res);
		logic [9:0] w;
		w = step_width(res);
		if (res == 4'h0)
			snap_position = pos;
		else
			snap_position = (pos & ~(w - 10'h001)) | (w >> 1);
	endfunction

	// Sine table entry, one full period over 1024 indices
	function automatic logic signed [8:0] sine_at(input logic [9:0] idx);
		logic [9:0]  x;
		logic [17:0] p;
		logic [26:0] num;
		logic [18:0] den;
		logic [7:0]  mag;
		x = {1'b0, idx[8:0]};
		p = 18'(x) * 18'(10'h200 - x);
		num = (27'(p) * `SINE_PEAK) << 2;
		den = `SINE_DEN - 19'(p);
		mag = 8'(num / 27'(den));
		sine_at = idx[9] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
	endfunction

	// Configuration fields
	always_comb begin
		dual_edge = chopper_config_reg[`CTRL_DUAL_EDGE];
		mres = (chopper_config_reg[`CTRL_MRES_LSB +: 4] > `MRES_MAX) ? `MRES_MAX
			: chopper_config_reg[`CTRL_MRES_LSB +: 4];
		regul_cfg.run_current_scale = current_cfg_reg[`CUR_RUN_LSB +: 5];
		regul_cfg.hold_current_scale = current_cfg_reg[`CUR_HOLD_LSB +: 5];
		regul_cfg.hold_sel = chopper_config_reg[`CTRL_HOLD_SEL];
		regul_cfg.min_quarter = chopper_config_reg[`CTRL_MIN_QUART];
		regul_cfg.load_filter = chopper_config_reg[`CTRL_FILTER];
		regul_cfg.lower_load_threshold = load_cfg_reg[`LD_LO_LSB +: 4];
		regul_cfg.upper_load_hysteresis = load_cfg_reg[`LD_HYST_LSB +: 4];
		regul_cfg.current_increment_step = load_cfg_reg[`LD_INC_LSB +: 2];
		regul_cfg.current_decrement_rate = load_cfg_reg[`LD_DEC_LSB +: 2];
		regul_cfg.cool_thrs = cool_thrs_reg[19:0];
		regul_cfg.upper_velocity_limit = velocity_limit_reg[19:0];
	end

	// Read multiplexer, unmapped words read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (address[5:2])
			`IDX_CTRL: rd_word = chopper_config_reg;
			`IDX_CURRENT: rd_word = current_cfg_reg;
			`IDX_LOAD: rd_word = load_cfg_reg;
			`IDX_COOL_THRS: rd_word = cool_thrs_reg;
			`IDX_VEL_LIMIT: rd_word = velocity_limit_reg;
			`IDX_STATUS: begin
				rd_word[`ST_MSC_LSB +: 10] = msc_reg;
				rd_word[`ST_CS_LSB +: 5] = cs_value;
				rd_word[`ST_ACTIVE] = cs_active;
			end
			`IDX_COIL: begin
				rd_word[`COIL_A_LSB +: 9] = coil_a_reg;
				rd_word[`COIL_B_LSB +: 9] = coil_b_reg;
			end
			`IDX_INTERVAL: rd_word[19:0] = step_interval_reg;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// Bus handshake: one wait cycle, then completion
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_state_reg <= step_seq_pkg::BUS_IDLE;
			waitrequest_reg <= 1'b1;
			readdata_reg <= 32'h0000_0000;
		end else begin
			unique case (bus_state_reg)
				step_seq_pkg::BUS_IDLE: begin
					if (read || write) begin
						bus_state_reg <= step_seq_pkg::BUS_ACK;
						waitrequest_reg <= 1'b0;
						readdata_reg <= read ? rd_word : 32'h0000_0000;
					end
				end
				step_seq_pkg::BUS_ACK: begin
					bus_state_reg <= step_seq_pkg::BUS_IDLE;
					waitrequest_reg <= 1'b1;
				end
				default: begin
					bus_state_reg <= step_seq_pkg::BUS_IDLE;
					waitrequest_reg <= 1'b1;
				end
			endcase
		end
	end

	// Register bank writes at the completing edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chopper_config_reg <= `RST_CTRL;
			current_cfg_reg <= `RST_CURRENT;
			load_cfg_reg <= `RST_LOAD;
			cool_thrs_reg <= `RST_COOL_THRS;
			velocity_limit_reg <= `RST_VEL_LIMIT;
		end else if (write && bus_state_reg == step_seq_pkg::BUS_ACK) begin
			unique case (address[5:2])
				`IDX_CTRL: chopper_config_reg <= be_merge(chopper_config_reg, writedata, byteenable, `MASK_CTRL);
				`IDX_CURRENT: current_cfg_reg <= be_merge(current_cfg_reg, writedata, byteenable, `MASK_CURRENT);
				`IDX_LOAD: load_cfg_reg <= be_merge(load_cfg_reg, writedata, byteenable, `MASK_LOAD);
				`IDX_COOL_THRS: cool_thrs_reg <= be_merge(cool_thrs_reg, writedata, byteenable, `MASK_THRS);
				`IDX_VEL_LIMIT: velocity_limit_reg <= be_merge(velocity_limit_reg, writedata, byteenable, `MASK_THRS);
				default: ;
			endcase
		end
	end

	// Two-stage synchronisers and edge history
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			step_meta_reg <= 1'b0;
			step_sync_reg <= 1'b0;
			step_prev_reg <= 1'b0;
			dir_meta_reg <= 1'b0;
			dir_sync_reg <= 1'b0;
		end else begin
			step_meta_reg <= step_in;
			step_sync_reg <= step_meta_reg;
			step_prev_reg <= step_sync_reg;
			dir_meta_reg <= dir_in;
			dir_sync_reg <= dir_meta_reg;
		end
	end

	// Active edge, pulses assumed no faster than the sampler
	always_comb begin
		if (dual_edge)
			step_event = step_sync_reg ^ step_prev_reg;
		else
			step_event = step_sync_reg & ~step_prev_reg;
	end

	// Microstep counter: snap to resolution, then move
	always_comb begin
		msc_base = snap_position(msc_reg, mres);
		if (step_event && !dir_sync_reg)
			msc_next = msc_base + step_width(mres);
		else if (step_event)
			msc_next = msc_base - step_width(mres);
		else
			msc_next = msc_base;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			msc_reg <= 10'h000;
		else
			msc_reg <= msc_next;
	end

	// Coil vectors read from the table, cosine a quarter ahead
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			coil_a_reg <= 9'h000;
			coil_b_reg <= 9'h000;
		end else begin
			coil_a_reg <= sine_at(msc_reg);
			coil_b_reg <= sine_at(msc_reg + `QUARTER_WAVE);
		end
	end

	// Clock count between active edges, saturating
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			interval_cnt_reg <= 20'h00000;
			step_interval_reg <= `INTERVAL_MAX;
		end else if (step_event) begin
			interval_cnt_reg <= 20'h00000;
			step_interval_reg <= interval_cnt_reg;
		end else if (interval_cnt_reg != `INTERVAL_MAX) begin
			interval_cnt_reg <= interval_cnt_reg + 20'h00001;
		end
	end

	// Adaptive current regulation
	current_regulator u_regulator (
		.clk              (clk),
		.rst              (rst),
		.cfg              (regul_cfg),
		.step_interval    (step_interval_reg),
		.load_in          (load_in),
		.current_scale_reg(cs_value),
		.regul_active_reg (cs_active)
	);

	// Output drive
	assign readdata = readdata_reg;
	assign waitrequest = waitrequest_reg;
	assign coil_a_current = coil_a_reg;
	assign coil_b_current = coil_b_reg;
	assign microstep_position = msc_reg;
	assign current_scale = cs_value;
	assign regulation_active = cs_active;
	assign load_threshold_trim = load_cfg_reg[`LD_TRIM_LSB +: 7];

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_rise_held;
		$rose(step_in) ##1 step_in ##1 step_in;
	endsequence

	sequence s_fall_held;
		$fell(step_in) ##1 !step_in ##1 !step_in;
	endsequence

	property p_rise_active;
		s_rise_held |-> step_event;
	endproperty
	a_rise_active: assert property (p_rise_active) else $error("rising step edge missed");

	property p_fall_edge;
		s_fall_held |-> (step_event == dual_edge);
	endproperty
	a_fall_edge: assert property (p_fall_edge) else $error("falling edge handling wrong");

	property p_step_fwd;
		step_event && !dir_sync_reg |=> msc_reg == $past(msc_base) + step_width($past(mres));
	endproperty
	a_step_fwd: assert property (p_step_fwd) else $error("forward step wrong");

	property p_step_back;
		step_event && dir_sync_reg |=> msc_reg == $past(msc_base) - step_width($past(mres));
	endproperty
	a_step_back: assert property (p_step_back) else $error("backward step wrong");

	property p_full_width;
		$stable(mres) && mres == 4'h8 && step_event && !dir_sync_reg ##1 mres == 4'h8 |-> msc_reg[7:0] == 8'h80
			&& msc_reg == $past(msc_reg) + 10'h100;
	endproperty
	a_full_width: assert property (p_full_width) else $error("full step width wrong");

	property p_snap;
		$changed(mres) |=> (msc_reg & (step_width($past(mres)) - 10'h001))
			== (step_width($past(mres)) >> 1) || $past(mres) == 4'h0;
	endproperty
	a_snap: assert property (p_snap) else $error("no snap after resolution change");

	property p_half_quarter;
		(mres == 4'h7 |=> msc_reg[6:0] == 7'h40) and (mres == 4'h6 |=> msc_reg[5:0] == 6'h20);
	endproperty
	a_half_quarter: assert property (p_half_quarter) else $error("half or quarter position wrong");

	property p_rms_level;
		mres == 4'h8 ##1 mres == 4'h8 |=> (coil_a_reg == $signed(`FULLSTEP_MAG) || coil_a_reg == -$signed(`FULLSTEP_MAG))
			&& (coil_b_reg == $signed(`FULLSTEP_MAG) || coil_b_reg == -$signed(`FULLSTEP_MAG));
	endproperty
	a_rms_level: assert property (p_rms_level) else $error("full step level not rms");

	property p_no_zero;
		mres != 4'h0 ##1 mres != 4'h0 |=> coil_a_reg != 9'h000 && coil_b_reg != 9'h000;
	endproperty
	a_no_zero: assert property (p_no_zero) else $error("reduced step hit zero entry");

endmodule // step_dir_microstep_sequencer
`default_nettype wire

// ---- step_ctrl_model.sv ----
/*
 Behavioural motion controller that sends one step pulse per request.
 Assumes the sequencer clock and a reset that is active high.
*/
`timescale 1ns/1ps
`default_nettype none
module step_ctrl_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Command from the bench
	input  wire logic go,
	input  wire logic dir_cmd,
	// Step link and status
	output logic      step_in,
	output logic      dir_in,
	output logic      busy
);
	logic [3:0] cnt_reg;

	assign busy = cnt_reg != 4'h0;

	// Pulse with four clocks high and low, dir held around it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 4'h0;
			step_in <= 1'b0;
			dir_in  <= 1'b0;
		end else if (go && !busy) begin
			cnt_reg <= 4'h1;
			dir_in  <= dir_cmd;
		end else if (busy) begin
			cnt_reg <= (cnt_reg == 4'hB) ? 4'h0 : cnt_reg + 4'h1;
			if (cnt_reg == 4'h3) begin
				step_in <= 1'b1;
			end
			if (cnt_reg == 4'h7) begin
				step_in <= 1'b0;
			end
		end
	end
endmodule // step_ctrl_model
`default_nettype wire

// ---- step_dir_microstep_sequencer_test.sv ----
/*
 Self-checking bench for the microstep sequencer.
 Assumes the design files and the controller model compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module step_dir_microstep_sequencer_test;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [5:0]        address = 6'h00;
	logic              read = 1'b0;
	logic              write = 1'b0;
	logic [31:0]       writedata = 32'h0;
	logic [31:0]       readdata;
	logic [31:0]       rd;
	logic              waitrequest;
	logic              step_in;
	logic              dir_in;
	logic              go = 1'b0;
	logic              dir_cmd = 1'b0;
	logic              busy;
	logic signed [8:0] coil_a_current;
	logic signed [8:0] coil_b_current;
	logic [9:0]        microstep_position;
	logic [4:0]        current_scale;
	logic              regulation_active;
	logic [6:0]        load_threshold_trim;
	step_seq_pkg::load_sample_t load_in = '0;
	int                fail_count = 0;
	int                comparisons = 0;

	// Clock of 200 MHz
	always #2.5 clk = ~clk;

	step_dir_microstep_sequencer u_step_dir_microstep_sequencer (.clk(clk), .rst(rst), .address(address),
		.read(read), .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .step_in(step_in), .dir_in(dir_in), .load_in(load_in),
		.coil_a_current(coil_a_current), .coil_b_current(coil_b_current), .microstep_position(microstep_position),
		.current_scale(current_scale), .regulation_active(regulation_active),
		.load_threshold_trim(load_threshold_trim));

	step_ctrl_model u_step_ctrl_model (.clk(clk), .rst(rst), .go(go), .dir_cmd(dir_cmd), .step_in(step_in),
		.dir_in(dir_in), .busy(busy));

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		read      <= ~wr;
		write     <= wr;
		address   <= a;
		writedata <= d;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask

	// One step pulse, then let position and coils settle
	task automatic stp(input logic d);
		@(posedge clk);
		go      <= 1'b1;
		dir_cmd <= d;
		@(posedge clk);
		go <= 1'b0;
		do begin
			@(posedge clk);
		end while (busy !== 1'b0);
		repeat (4) @(posedge clk);
	endtask

	// Reset values, masking and an unmapped word
	task automatic t_regs;
		bus(1'b0, 6'h04, 32'h0);
		chk(rd, 32'h0000_0810);
		bus(1'b1, 6'h00, 32'hFFFF_FF00);
		bus(1'b0, 6'h00, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 6'h20, 32'h0);
		chk(rd, 32'h0);
	endtask

	// Wrap across the end of the table at width 1
	task automatic t_wrap;
		stp(1'b1);
		chk(32'(microstep_position), 32'h3FF);
		stp(1'b0);
		chk(32'(microstep_position), 32'h0);
	endtask

	// Quarter then half step, with snapping on each drop
	task automatic t_fine;
		bus(1'b1, 6'h00, 32'h0C);
		repeat (3) @(posedge clk);
		chk(32'(microstep_position), 32'h20);
		stp(1'b0);
		chk(32'(microstep_position), 32'h60);
		bus(1'b1, 6'h00, 32'h0E);
		repeat (3) @(posedge clk);
		chk(32'(microstep_position), 32'h40);
		stp(1'b0);
		chk(32'(microstep_position), 32'hC0);
	endtask

	// Full step cycle with equal coil magnitude
	task automatic t_full;
		int i;
		bus(1'b1, 6'h00, 32'h10);
		repeat (3) @(posedge clk);
		chk(32'(microstep_position), 32'h80);
		chk(32'(coil_a_current), 32'h0000_00AF);
		chk(32'(coil_b_current), 32'h0000_00AF);
		for (i = 1; i < 5; i++) begin
			stp(1'b0);
			chk(32'(microstep_position), 32'((128 + 256 * i) % 1024));
		end
		stp(1'b1);
		chk(32'(microstep_position), 32'h380);
	endtask

	// Dual edge counts both edges, single edge only rising
	task automatic t_edges;
		bus(1'b1, 6'h00, 32'h01);
		stp(1'b0);
		chk(32'(microstep_position), 32'h382);
		bus(1'b1, 6'h00, 32'h00);
		stp(1'b0);
		chk(32'(microstep_position), 32'h383);
	endtask

	// One load reading strobe, one cycle wide
	task automatic reading(input logic [9:0] v);
		@(posedge clk);
		load_in <= {1'b1, v};
		@(posedge clk);
		load_in <= '0;
		repeat (2) @(posedge clk);
	endtask

	// Scale falls on high readings to its floor, rises on a low one
	task automatic t_regul;
		int i;
		bus(1'b1, 6'h08, 32'h0005_5C01);
		bus(1'b1, 6'h0C, 32'h000F_FFFF);
		repeat (3) @(posedge clk);
		chk(32'(load_threshold_trim), 32'h0000_0055);
		chk(32'(regulation_active), 32'h0000_0001);
		chk(32'(current_scale), 32'h0000_0010);
		for (i = 0; i < 10; i++) begin
			reading(10'h3FF);
		end
		chk(32'(current_scale), 32'h0000_0008);
		reading(10'h000);
		chk(32'(current_scale), 32'h0000_0009);
		bus(1'b1, 6'h08, 32'h0000_0000);
		repeat (3) @(posedge clk);
		chk(32'(regulation_active), 32'h0000_0000);
		chk(32'(current_scale), 32'h0000_0010);
	endtask

	// Count summary and verdict
	task automatic results;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_wrap();
		t_fine();
		t_full();
		t_edges();
		t_regul();
		results();
	end

	// Watchdog
	initial begin
		#200000;
		fail_count++;
		results();
	end
endmodule // step_dir_microstep_sequencer_test
`default_nettype wire
